// ==== hw/console_typewriter_io.sv ====
`timescale 1ns/1ps
`include "console_typewriter_io_map.svh"
// Operation
// - Manual entry only while processor halted
// - Eight characters; ninth discards held eight
// - Store R at instruction operand address
// - Keyboard locked unless entry or program unlock
// - Input words fill consecutive memory locations
// - Count: tens, units, plus 100, 200
// - Open-ended code runs until stop key
// - Stop mid-word pads zeros before storing
// - Stop code never enters R or memory
// - Print counted words from operand address
// - Tab after each word unless inhibited
// - Carriage return at start, margin, end
// - Print inhibit makes print a no-op
// - Zero count: two returns, no printing
// - Indexed address, tagged halt, flag return
// - Only one manual entry target active
module console_typewriter_io (
  // Clocking
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Console controls
  input wire logic halted,
  input wire logic enterInstrBtn,
  input wire logic enterRBtn,
  input wire logic storeBtn,
  input wire logic printInhibit,
  input wire logic tabInhibit,
  input wire logic programUnlock,
  // Instruction start
  input wire logic opStart,
  input wire logic opIsPrint,
  input wire logic [`CHAR_W-1:0] countZ,
  input wire logic [`CHAR_W-1:0] countY,
  input wire logic [`ADDR_W-1:0] effAddr,
  input wire logic opTagged,
  input wire logic opFlagReturn,
  // Instruction finish
  output logic opDone,
  output logic tagHalt,
  output logic flagReturn,
  // Core memory
  output logic memReq,
  output logic memWe,
  output logic [`ADDR_W-1:0] memAddr,
  output logic [`WORD_W-1:0] memWdata,
  input wire logic [`WORD_W-1:0] memRdata,
  input wire logic memAck,
  // Keyboard
  input wire logic keyValid,
  input wire logic [`CHAR_W-1:0] keyChar,
  input wire logic keyStop,
  output logic keyReady,
  output logic keyboardLocked,
  // Printer
  output logic prValid,
  output console_typewriter_io_pkg::print_kind_t prKind,
  output logic [`CHAR_W-1:0] prChar,
  input wire logic prReady,
  // Visible registers
  output logic [`WORD_W-1:0] instrReg,
  output logic [`WORD_W-1:0] rReg
);
  import console_typewriter_io_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_IN, S_IN_END, S_P_CR0, S_P_FETCH, S_P_CHAR,
    S_P_TAB, S_P_CR1, S_P_CR2, S_DONE
  } state_t;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  state_t state_r, state_nxt;
  entry_sel_t sel_r, sel_nxt;
  logic [`WORD_W-1:0] instr_r, instr_nxt, r_r, r_nxt;
  logic [3:0] chars_r, chars_nxt;
  logic [`CNT_W-1:0] target_r, target_nxt, done_r, done_nxt;
  logic [`CNT_W-1:0] stored_r, stored_nxt;
  logic openEnd_r, openEnd_nxt, stop_r, stop_nxt;
  logic tag_r, tag_nxt, flag_r, flag_nxt;
  logic [`ADDR_W-1:0] ptr_r, ptr_nxt, memAddr_r, memAddr_nxt;
  logic [`WORD_W-1:0] memWdata_r, memWdata_nxt;
  logic memReq_r, memReq_nxt, memWe_r, memWe_nxt;
  logic prValid_r, prValid_nxt;
  print_kind_t prKind_r, prKind_nxt;
  logic [`CHAR_W-1:0] prChar_r, prChar_nxt;
  logic [`COL_W-1:0] col_r, col_nxt;
  logic opDone_r, opDone_nxt, tagHalt_r, tagHalt_nxt;
  logic flagRet_r, flagRet_nxt;
  logic keyReady_r, keyReady_nxt, locked_r, locked_nxt;
  // FIFO wiring
  logic fifoInValid, fifoInReady, fifoAFull;
  logic fifoOutValid, fifoOutReady;
  logic [`WORD_W-1:0] fifoInData, fifoOutData;
  logic [`CNT_W-1:0] decCount;
  logic decOpen, keyTake;

  // ---------------------------------------------------------------
  // Count decode
  // ---------------------------------------------------------------
  always_comb begin
    decCount = `CNT_W'(countZ[3:0]) * `CNT_TEN
      + `CNT_W'(countY[3:0])
      + (countY[`HUNDRED_BIT] ? `CNT_HUNDRED : '0)
      + (countY[`TWO_HUNDRED_BIT] ? `CNT_TWO_HUNDRED : '0);
    decOpen = (countZ == `OPEN_Z_CODE) && (countY == `ZERO_CODE);
  end

  // ---------------------------------------------------------------
  // Input word buffer
  // ---------------------------------------------------------------
  word_fifo #(.WIDTH(`WORD_W), .DEPTH(`FIFO_DEPTH)) inBuf (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(fifoInData),
    .almostFull(fifoAFull),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  assign keyTake = keyValid && keyReady_r;
  assign fifoOutReady = (state_r == S_IN || state_r == S_IN_END)
    && !memReq_r;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    sel_nxt = sel_r;
    instr_nxt = instr_r;
    r_nxt = r_r;
    chars_nxt = chars_r;
    target_nxt = target_r;
    done_nxt = done_r;
    stored_nxt = stored_r;
    openEnd_nxt = openEnd_r;
    stop_nxt = stop_r;
    tag_nxt = tag_r;
    flag_nxt = flag_r;
    ptr_nxt = ptr_r;
    memAddr_nxt = memAddr_r;
    memWdata_nxt = memWdata_r;
    memReq_nxt = memReq_r;
    memWe_nxt = memWe_r;
    prValid_nxt = prValid_r;
    prKind_nxt = prKind_r;
    prChar_nxt = prChar_r;
    col_nxt = col_r;
    opDone_nxt = 1'b0;
    tagHalt_nxt = 1'b0;
    flagRet_nxt = 1'b0;
    fifoInValid = 1'b0;
    fifoInData = '0;
    if (prValid_r && prReady)
      prValid_nxt = 1'b0;
    if (memReq_r && memAck) begin
      memReq_nxt = 1'b0;
      if (memWe_r && state_r != S_IDLE) begin
        ptr_nxt = ptr_r + 1'b1;
        stored_nxt = stored_r + 1'b1;
      end
      if (!memWe_r)
        r_nxt = memRdata;
    end
    if (halted && state_r == S_IDLE) begin
      if (enterInstrBtn)
        sel_nxt = SEL_INSTR;
      else if (enterRBtn)
        sel_nxt = SEL_R;
    end
    unique case (state_r)
      S_IDLE: begin
        if (halted && keyTake && !keyStop && sel_r != SEL_NONE) begin
          chars_nxt = (chars_r == `WORD_CHARS) ? 4'h1 : chars_r + 4'h1;
          if (sel_r == SEL_INSTR)
            instr_nxt = (chars_r == `WORD_CHARS)
              ? `WORD_W'(keyChar) : {instr_r[`WORD_W-`CHAR_W-1:0], keyChar};
          else
            r_nxt = (chars_r == `WORD_CHARS)
              ? `WORD_W'(keyChar) : {r_r[`WORD_W-`CHAR_W-1:0], keyChar};
        end
        if (halted && storeBtn && !memReq_r) begin
          memReq_nxt = 1'b1;
          memWe_nxt = 1'b1;
          memAddr_nxt = instr_r[`OPA_HI:`OPA_LO];
          memWdata_nxt = r_r;
        end
        if (opStart && !halted) begin
          ptr_nxt = effAddr;
          tag_nxt = opTagged;
          flag_nxt = opFlagReturn;
          target_nxt = decCount;
          openEnd_nxt = decOpen && !opIsPrint;
          stop_nxt = 1'b0;
          done_nxt = '0;
          stored_nxt = '0;
          chars_nxt = '0;
          if (opIsPrint && printInhibit)
            state_nxt = S_DONE;
          else if (opIsPrint)
            state_nxt = S_P_CR0;
          else if (decCount == '0 && !decOpen)
            state_nxt = S_DONE;
          else
            state_nxt = S_IN;
        end
      end
      S_IN: begin
        if (keyTake && keyStop) begin
          state_nxt = S_IN_END;
          stop_nxt = 1'b1;
          if (chars_r != '0) begin
            fifoInValid = 1'b1;
            fifoInData = r_r << (`CHAR_W * (`WORD_CHARS - chars_r));
            done_nxt = done_r + 1'b1;
            r_nxt = '0;
          end
          chars_nxt = '0;
        end else if (keyTake) begin
          r_nxt = {r_r[`WORD_W-`CHAR_W-1:0], keyChar};
          chars_nxt = chars_r + 4'h1;
          if (chars_r == `WORD_CHARS - 4'h1) begin
            fifoInValid = 1'b1;
            fifoInData = {r_r[`WORD_W-`CHAR_W-1:0], keyChar};
            chars_nxt = '0;
            done_nxt = done_r + 1'b1;
            if (!openEnd_r && done_r + 1'b1 == target_r)
              state_nxt = S_IN_END;
          end
        end
      end
      S_IN_END: begin
        if (!fifoOutValid && !memReq_r && stored_r == done_r)
          state_nxt = S_DONE;
      end
      S_P_CR0: begin
        if (!prValid_r) begin
          prValid_nxt = 1'b1;
          prKind_nxt = PR_CR;
          col_nxt = '0;
          state_nxt = (target_r == '0) ? S_P_CR1 : S_P_FETCH;
        end
      end
      S_P_FETCH: begin
        if (!memReq_r && !memWe_r && chars_r == `WORD_CHARS) begin
          chars_nxt = '0;
          state_nxt = S_P_CHAR;
        end else if (!memReq_r && chars_r != `WORD_CHARS) begin
          memReq_nxt = 1'b1;
          memWe_nxt = 1'b0;
          memAddr_nxt = ptr_r;
          ptr_nxt = ptr_r + 1'b1;
          chars_nxt = `WORD_CHARS;
        end
      end
      S_P_CHAR: begin
        if (!prValid_r) begin
          prValid_nxt = 1'b1;
          if (col_r >= `RIGHT_MARGIN) begin
            prKind_nxt = PR_CR;
            col_nxt = '0;
          end else begin
            prKind_nxt = PR_CHAR;
            prChar_nxt = r_r[`WORD_W-1 -: `CHAR_W];
            r_nxt = r_r << `CHAR_W;
            col_nxt = col_r + 1'b1;
            chars_nxt = chars_r + 4'h1;
            if (chars_r == `WORD_CHARS - 4'h1) begin
              done_nxt = done_r + 1'b1;
              chars_nxt = '0;
              if (!tabInhibit)
                state_nxt = S_P_TAB;
              else if (done_r + 1'b1 == target_r)
                state_nxt = S_P_CR1;
              else
                state_nxt = S_P_FETCH;
            end
          end
        end
      end
      S_P_TAB: begin
        if (!prValid_r) begin
          prValid_nxt = 1'b1;
          prKind_nxt = PR_TAB;
          col_nxt = (col_r | `TAB_MASK) + 1'b1;
          state_nxt = (done_r == target_r) ? S_P_CR1 : S_P_FETCH;
        end
      end
      S_P_CR2, S_P_CR1: begin
        if (!prValid_r) begin
          prValid_nxt = 1'b1;
          prKind_nxt = PR_CR;
          col_nxt = '0;
          state_nxt = (state_r == S_P_CR2) ? S_P_CR1 : S_DONE;
        end
      end
      S_DONE: begin
        if (!prValid_r) begin
          opDone_nxt = 1'b1;
          tagHalt_nxt = tag_r;
          flagRet_nxt = flag_r;
          state_nxt = S_IDLE;
        end
      end
    endcase
    if (fifoOutValid && fifoOutReady) begin
      memReq_nxt = 1'b1;
      memWe_nxt = 1'b1;
      memAddr_nxt = ptr_r;
      memWdata_nxt = fifoOutData;
    end
    keyReady_nxt = (state_nxt == S_IN) ? !fifoAFull
      : (state_nxt == S_IDLE && halted && sel_nxt != SEL_NONE);
    locked_nxt = !((halted && sel_nxt != SEL_NONE && state_nxt == S_IDLE)
      || programUnlock || state_nxt == S_IN);
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r <= S_IDLE;
      sel_r <= SEL_NONE;
      instr_r <= '0;
      r_r <= '0;
      chars_r <= '0;
      target_r <= '0;
      done_r <= '0;
      stored_r <= '0;
      openEnd_r <= 1'b0;
      stop_r <= 1'b0;
      tag_r <= 1'b0;
      flag_r <= 1'b0;
      ptr_r <= '0;
      memAddr_r <= '0;
      memWdata_r <= '0;
      memReq_r <= 1'b0;
      memWe_r <= 1'b0;
      prValid_r <= 1'b0;
      prKind_r <= PR_CHAR;
      prChar_r <= '0;
      col_r <= '0;
      opDone_r <= 1'b0;
      tagHalt_r <= 1'b0;
      flagRet_r <= 1'b0;
      keyReady_r <= 1'b0;
      locked_r <= 1'b1;
    end else if (ce) begin
      state_r <= state_nxt;
      sel_r <= sel_nxt;
      instr_r <= instr_nxt;
      r_r <= r_nxt;
      chars_r <= chars_nxt;
      target_r <= target_nxt;
      done_r <= done_nxt;
      stored_r <= stored_nxt;
      openEnd_r <= openEnd_nxt;
      stop_r <= stop_nxt;
      tag_r <= tag_nxt;
      flag_r <= flag_nxt;
      ptr_r <= ptr_nxt;
      memAddr_r <= memAddr_nxt;
      memWdata_r <= memWdata_nxt;
      memReq_r <= memReq_nxt;
      memWe_r <= memWe_nxt;
      prValid_r <= prValid_nxt;
      prKind_r <= prKind_nxt;
      prChar_r <= prChar_nxt;
      col_r <= col_nxt;
      opDone_r <= opDone_nxt;
      tagHalt_r <= tagHalt_nxt;
      flagRet_r <= flagRet_nxt;
      keyReady_r <= keyReady_nxt;
      locked_r <= locked_nxt;
    end
  end

  assign opDone = opDone_r;
  assign tagHalt = tagHalt_r;
  assign flagReturn = flagRet_r;
  assign memReq = memReq_r;
  assign memWe = memWe_r;
  assign memAddr = memAddr_r;
  assign memWdata = memWdata_r;
  assign keyReady = keyReady_r;
  assign keyboardLocked = locked_r;
  assign prValid = prValid_r;
  assign prKind = prKind_r;
  assign prChar = prChar_r;
  assign instrReg = instr_r;
  assign rReg = r_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_entry_needs_halt: assert property (@(posedge clk) disable iff (!nrst)
    ce && !halted && state_r == S_IDLE |=> $stable(instr_r))
    else $error("instruction register changed while running");
  a_ninth_char_clears: assert property (@(posedge clk)
    disable iff (!nrst) ce && halted && state_r == S_IDLE && keyTake
    && !keyStop && sel_r == SEL_R && chars_r == `WORD_CHARS
    |=> r_r == `WORD_W'($past(keyChar)))
    else $error("ninth character kept old contents");
  a_store_address: assert property (@(posedge clk) disable iff (!nrst)
    ce && halted && storeBtn && !memReq_r && state_r == S_IDLE
    |=> memReq_r && memWe_r && memAddr_r == $past(instr_r[`OPA_HI:`OPA_LO]))
    else $error("store used wrong address");
  a_keyboard_lock: assert property (@(posedge clk) disable iff (!nrst)
    ce && !halted && !programUnlock && state_nxt == S_IDLE |=> locked_r)
    else $error("keyboard unlocked without cause");
  a_stop_not_data: assert property (@(posedge clk) disable iff (!nrst)
    ce && state_r == S_IN && keyTake && keyStop |=> stop_r
    && state_r == S_IN_END && chars_r == '0)
    else $error("stop code treated as data");
  a_inhibit_noop: assert property (@(posedge clk) disable iff (!nrst)
    ce && state_r == S_IDLE && opStart && !halted && opIsPrint
    && printInhibit |=> state_r == S_DONE && !prValid_r)
    else $error("inhibited print did not skip");
  a_one_target: assert property (@(posedge clk) disable iff (!nrst)
    ce && halted && state_r == S_IDLE && enterRBtn && !enterInstrBtn
    |=> sel_r == SEL_R)
    else $error("R entry not selected");
  a_done_flags: assert property (@(posedge clk) disable iff (!nrst)
    tagHalt_r || flagRet_r |-> opDone_r)
    else $error("flag without completion");
  a_tab_advance: assert property (@(posedge clk) disable iff (!nrst)
    ce && state_r == S_P_TAB && !prValid_r |=> prValid_r
    && prKind_r == PR_TAB && col_r[2:0] == 3'h0)
    else $error("tab not issued on stop");
endmodule : console_typewriter_io

// ==== hw/console_typewriter_io_map.svh ====
`ifndef CONSOLE_TYPEWRITER_IO_MAP_SVH
`define CONSOLE_TYPEWRITER_IO_MAP_SVH
// ---------------------------------------------------------------
// Widths
// ---------------------------------------------------------------
`define CHAR_W 6
`define WORD_CHARS 4'h8
`define WORD_W 48
`define ADDR_W 16
`define CNT_W 9
`define COL_W 7
`define FIFO_DEPTH 8
// ---------------------------------------------------------------
// Count field decode
// ---------------------------------------------------------------
`define CNT_TEN 9'h00A
`define CNT_HUNDRED 9'h064
`define CNT_TWO_HUNDRED 9'h0C8
`define HUNDRED_BIT 4
`define TWO_HUNDRED_BIT 5
`define OPEN_Z_CODE 6'h25
`define ZERO_CODE 6'h00
// ---------------------------------------------------------------
// Operand address inside the instruction register
// ---------------------------------------------------------------
`define OPA_HI 15
`define OPA_LO 0
// ---------------------------------------------------------------
// Carriage
// ---------------------------------------------------------------
`define RIGHT_MARGIN 7'h55
`define TAB_MASK 7'h07
`endif

// ==== hw/console_typewriter_io_pkg.sv ====
package console_typewriter_io_pkg;
  typedef enum logic [1:0] {
    PR_CHAR, PR_TAB, PR_CR
  } print_kind_t;
  typedef enum logic [1:0] {
    SEL_NONE, SEL_INSTR, SEL_R
  } entry_sel_t;
endpackage : console_typewriter_io_pkg

// ==== hw/word_fifo.sv ====
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 8
) (
  // Clocking
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic almostFull,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r, rdPtr_r;
  logic [AW:0] count_r;
  logic push, pop;

  assign inReady = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign almostFull = (count_r >= (AW+1)'(DEPTH - 1));
  assign outData = mem[rdPtr_r];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else if (ce) begin
      if (push) begin
        mem[wrPtr_r] <= inData;
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (pop)
        rdPtr_r <= rdPtr_r + 1'b1;
      if (push && !pop)
        count_r <= count_r + 1'b1;
      else if (pop && !push)
        count_r <= count_r - 1'b1;
    end
  end
endmodule : word_fifo

// ==== tb/console_typewriter_io_tb.sv ====
`timescale 1ns/1ps
`include "console_typewriter_io_map.svh"
module console_typewriter_io_tb;
  import console_typewriter_io_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic halted = 1'b0;
  logic enterInstrBtn = 1'b0;
  logic enterRBtn = 1'b0;
  logic storeBtn = 1'b0;
  logic printInhibit = 1'b0;
  logic tabInhibit = 1'b0;
  logic programUnlock = 1'b0;
  logic opStart = 1'b0;
  logic opIsPrint = 1'b0;
  logic [`CHAR_W-1:0] countZ = '0;
  logic [`CHAR_W-1:0] countY = '0;
  logic [`ADDR_W-1:0] effAddr = '0;
  logic opTagged = 1'b0;
  logic opFlagReturn = 1'b0;
  logic [`WORD_W-1:0] memRdata = '0;
  logic memAck = 1'b0;
  logic opDone, tagHalt, flagReturn, memReq, memWe;
  logic [`ADDR_W-1:0] memAddr;
  logic [`WORD_W-1:0] memWdata, instrReg, rReg;
  logic keyValid, keyStop, keyReady, keyboardLocked, prValid, prReady;
  logic [`CHAR_W-1:0] keyChar, prChar;
  print_kind_t prKind;
  logic [`WORD_W-1:0] mem[int];
  int memLat = 1;
  int memWait = 0;
  int errTotal = 0;
  int nTests = 0;
  logic sawTag, sawFlag;
  always #2 clk = ~clk;
  console_typewriter_io dut (.clk, .nrst, .ce, .halted, .enterInstrBtn,
    .enterRBtn, .storeBtn, .printInhibit, .tabInhibit, .programUnlock,
    .opStart, .opIsPrint, .countZ, .countY, .effAddr, .opTagged,
    .opFlagReturn, .opDone, .tagHalt, .flagReturn, .memReq, .memWe,
    .memAddr, .memWdata, .memRdata, .memAck, .keyValid, .keyChar,
    .keyStop, .keyReady, .keyboardLocked, .prValid, .prKind, .prChar,
    .prReady, .instrReg, .rReg);
  typewriter_model tw (.clk, .keyValid, .keyChar, .keyStop, .keyReady,
    .prValid, .prKind, .prChar, .prReady);
  // ----
  // Core memory with adjustable latency
  // ----
  always @(posedge clk) begin
    memAck <= 1'b0;
    if (memReq === 1'b1 && memAck !== 1'b1 && memWait >= memLat) begin
      memWait <= 0;
      memAck <= 1'b1;
      if (memWe) mem[memAddr] = memWdata;
      else memRdata <= mem.exists(memAddr) ? mem[memAddr] : {32'h0, memAddr};
    end else begin
      memWait <= (memReq === 1'b1) ? memWait + 1 : 0;
      memRdata <= ~memRdata;
    end
  end
  // ----
  // Helpers
  // ----
  task automatic check(input string what, input logic [`WORD_W-1:0] seen,
                       input logic [`WORD_W-1:0] exp);
    nTests++;
    if (seen !== exp) begin
      errTotal++;
      $display("BAD %s exp=%h seen=%h", what, exp, seen);
    end
  endtask : check
  function automatic logic [`WORD_W-1:0] kd(input int i);
    return {46'h0, tw.printed[i][7:6]};
  endfunction : kd
  task automatic wrapUp();
    $display("checks=%0d mismatches=%0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrapUp
  task automatic press(input int b);
    enterRBtn <= (b == 0);
    enterInstrBtn <= (b == 1);
    storeBtn <= (b == 2);
    @(posedge clk);
    enterRBtn <= 1'b0;
    enterInstrBtn <= 1'b0;
    storeBtn <= 1'b0;
    @(posedge clk);
  endtask : press
  task automatic typeWord(input logic [`WORD_W-1:0] w, input int nch);
    for (int i = 0; i < nch; i++) tw.typeKey(w[47-6*i -: 6], 1'b0);
  endtask : typeWord
  task automatic startOp(input logic pr, input logic [5:0] z, y,
                         input logic [15:0] a, input logic tg, fr);
    tw.printed.delete();
    opStart <= 1'b1;
    opIsPrint <= pr;
    countZ <= z;
    countY <= y;
    effAddr <= a;
    opTagged <= tg;
    opFlagReturn <= fr;
    @(posedge clk);
    opStart <= 1'b0;
  endtask : startOp
  task automatic waitDone();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (opDone !== 1'b1 && n < 20000);
    sawTag = tagHalt;
    sawFlag = flagReturn;
    check("opDone", {47'h0, opDone}, 48'h1);
  endtask : waitDone
  // ----
  // Scenarios
  // ----
  task automatic t_manual();
    int n;
    press(0);
    press(2);
    repeat (3) @(posedge clk);
    check("keyReadyRun", {47'h0, keyReady}, 48'h0);
    check("memReqRun", {47'h0, memReq}, 48'h0);
    check("lockedRun", {47'h0, keyboardLocked}, 48'h1);
    halted <= 1'b1;
    @(posedge clk);
    press(0);
    @(posedge clk);
    check("unlocked", {47'h0, keyboardLocked}, 48'h0);
    typeWord(48'h123456789ABC, 8);
    check("rReg8", rReg, 48'h123456789ABC);
    typeWord(48'hFC5A5A5A5A5A, 1);
    check("rReg9", rReg, 48'h3F);
    typeWord(48'hFC5A5A5A5A5A << 6, 7);
    check("rRegRefill", rReg, 48'hFC5A5A5A5A5A);
    press(1);
    typeWord(48'hABCDEF000345, 8);
    check("instrReg", instrReg, 48'hABCDEF000345);
    check("rRegKept", rReg, 48'hFC5A5A5A5A5A);
    press(2);
    n = 0;
    while (memAck !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    check("stored", mem[16'h0345], 48'hFC5A5A5A5A5A);
    halted <= 1'b0;
    @(posedge clk);
  endtask : t_manual
  task automatic t_input();
    programUnlock <= 1'b1;
    memLat = 100;
    startOp(1'b0, 6'h01, 6'h02, 16'h0100, 1'b1, 1'b0);
    for (int i = 0; i < 12; i++) typeWord({16'(i), 32'h89ABCDEF}, 8);
    waitDone();
    check("tagHalt", {47'h0, sawTag}, 48'h1);
    for (int i = 0; i < 12; i++) begin
      check("inWord", mem[16'h0100 + i], {16'(i), 32'h89ABCDEF});
    end
    check("inCount", {47'h0, mem.exists(16'h010C)}, 48'h0);
    memLat = 1;
    startOp(1'b0, 6'h25, 6'h00, 16'h0200, 1'b0, 1'b1);
    typeWord(48'hFEDCBA987654, 8);
    typeWord(48'h0F1E2D3C4B5A, 3);
    tw.typeKey(6'h00, 1'b1);
    waitDone();
    check("flagIn", {47'h0, sawFlag}, 48'h1);
    check("openWord", mem[16'h0200], 48'hFEDCBA987654);
    check("padWord", mem[16'h0201], 48'h0F1E00000000);
    check("noStop", {47'h0, mem.exists(16'h0202)}, 48'h0);
    programUnlock <= 1'b0;
  endtask : t_input
  task automatic t_print();
    mem[16'h0300] = 48'h123456789ABC;
    mem[16'h0301] = 48'h0F1E2D3C4B5A;
    startOp(1'b1, 6'h00, 6'h01, 16'h0300, 1'b0, 1'b1);
    waitDone();
    check("flagPr", {47'h0, sawFlag}, 48'h1);
    check("prLen", tw.printed.size(), 48'd11);
    check("crFirst", kd(0), 48'(PR_CR));
    for (int i = 1; i < 9; i++) begin
      check("prChar", {40'h0, tw.printed[i]},
            {40'h0, 2'(PR_CHAR), 6'(48'h123456789ABC >> (48 - 6*i))});
    end
    check("tab", kd(9), 48'(PR_TAB));
    check("crLast", kd(10), 48'(PR_CR));
    tabInhibit <= 1'b1;
    tw.slow = 1'b1;
    startOp(1'b1, 6'h00, 6'h02, 16'h0300, 1'b0, 1'b0);
    waitDone();
    check("prLenNoTab", tw.printed.size(), 48'd18);
    check("word2", {42'h0, tw.printed[9][5:0]}, 48'h03);
    check("crEnd", kd(17), 48'(PR_CR));
    startOp(1'b1, 6'h00, 6'h00, 16'h0300, 1'b0, 1'b0);
    waitDone();
    check("zeroLen", tw.printed.size(), 48'd2);
    check("zeroCr", kd(0) & kd(1), 48'(PR_CR));
    printInhibit <= 1'b1;
    startOp(1'b1, 6'h00, 6'h01, 16'h0300, 1'b0, 1'b0);
    waitDone();
    check("inhLen", tw.printed.size(), 48'd0);
    printInhibit <= 1'b0;
    tabInhibit <= 1'b0;
    tw.slow = 1'b0;
  endtask : t_print
  task automatic t_big();
    int ch, tb, cr;
    ch = 0;
    tb = 0;
    cr = 0;
    startOp(1'b1, 6'h01, 6'h33, 16'h1000, 1'b0, 1'b0);
    waitDone();
    for (int i = 0; i < tw.printed.size(); i++) begin
      if (kd(i) === 48'(PR_CHAR)) ch++;
      if (kd(i) === 48'(PR_TAB)) tb++;
      if (kd(i) === 48'(PR_CR)) cr++;
    end
    check("bigChars", 48'(ch), 48'd2504);
    check("bigTabs", 48'(tb), 48'd313);
    check("marginCr", {47'h0, cr > 2}, 48'h1);
  endtask : t_big
  // ----
  // Main sequence and watchdog
  // ----
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    check("lockedRst", {47'h0, keyboardLocked}, 48'h1);
    t_manual();
    t_input();
    t_print();
    t_big();
    check("keyTimeouts", 48'(tw.keyTimeouts), 48'h0);
    wrapUp();
  end
  initial begin
    repeat (60000) @(posedge clk);
    errTotal++;
    wrapUp();
  end
endmodule : console_typewriter_io_tb

// ==== tb/typewriter_model.sv ====
`timescale 1ns/1ps
`include "console_typewriter_io_map.svh"
module typewriter_model (
  // Clocking
  input wire logic clk,
  // Keyboard
  output logic keyValid,
  output logic [`CHAR_W-1:0] keyChar,
  output logic keyStop,
  input wire logic keyReady,
  // Printer
  input wire logic prValid,
  input wire console_typewriter_io_pkg::print_kind_t prKind,
  input wire logic [`CHAR_W-1:0] prChar,
  output logic prReady
);
  import console_typewriter_io_pkg::*;
  logic [7:0] printed[$];
  logic slow;
  int cyc;
  int keyTimeouts;
  initial begin
    keyTimeouts = 0;
    keyValid = 1'b0;
    keyChar = '0;
    keyStop = 1'b0;
    prReady = 1'b0;
    slow = 1'b0;
    cyc = 0;
  end
  // ----
  // Keyboard, one 6-bit code per key
  // ----
  task automatic typeKey(input logic [`CHAR_W-1:0] c, input logic stop);
    int n;
    n = 0;
    keyValid <= 1'b1;
    keyChar <= c;
    keyStop <= stop;
    do begin
      @(posedge clk);
      n++;
    end while (keyReady !== 1'b1 && n < 500);
    if (keyReady !== 1'b1)
      keyTimeouts++;
    keyValid <= 1'b0;
    keyChar <= ~c;
    keyStop <= 1'b0;
    @(posedge clk);
  endtask : typeKey
  // ----
  // Printer, optionally stalling
  // ----
  always @(posedge clk) begin
    if (prValid === 1'b1 && prReady === 1'b1) begin
      printed.push_back({prKind, prChar});
    end
    cyc <= cyc + 1;
    prReady <= !slow || (cyc % 3 == 0);
  end
endmodule : typewriter_model
